// file: shared/pdmiw_pkg.sv
// package for the power-down and multi-input wakeup block
package pdmiw_pkg;
  // port b configuration selector values
  localparam logic [7:0] SEL_DIR = 8'h0F;
  localparam logic [7:0] SEL_EDGE = 8'h0A;
  localparam logic [7:0] SEL_PEND = 8'h09;
  localparam logic [7:0] SEL_EN = 8'h0B;
  // reset values of the enable mask, edge select and pin direction
  localparam logic [7:0] EN_RESET = 8'hFF;
  localparam logic [7:0] EDGE_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  // program counter value loaded by reset and by a pin wakeup
  localparam logic [10:0] PC_RESET = 11'h7FF;
  localparam int NPIN = 8;
  // watchdog counter width, a plain default
  localparam int WDT_W = 16;
  localparam logic [WDT_W-1:0] WDT_ZERO = '0;
  localparam logic [WDT_W-1:0] WDT_ONE = 16'h0001;
  localparam logic [WDT_W-1:0] WDT_MAX = 16'hFFFF;
  // run state, gray coded except the WAKE to RUN step, which flips both bits
  typedef enum logic [1:0] {
    PDMIW_RUN = 2'b00,
    PDMIW_SLEEP = 2'b01,
    PDMIW_WAKE = 2'b11
  } pdmiw_state_e;
  // configuration write request from the core
  typedef struct packed {
    logic       wr;
    logic [7:0] sel;
    logic [7:0] data;
  } pdmiw_cfg_s;
  // status flags shown to the core
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } pdmiw_stat_s;
endpackage

// file: verilog/pdmiw_edge.sv
// one-bit synchroniser, edge detector and pending latch
`timescale 1ns/1ps
module pdmiw_edge (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_pin,
  input wire logic i_edge_fall,
  input wire logic i_wr_pend,
  input wire logic i_wr_val,
  output logic o_pend
);
  logic sync1_ff; // first stage, read only by sync2_ff
  logic sync2_ff; // second stage
  logic prev_ff; // previous synchronised level
  logic pend_ff; // pending latch, no reset
  logic hit; // selected edge seen this cycle

  // two-flop synchroniser and delay
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      // start from the pin's own level so that no false edge follows reset
      sync1_ff <= i_pin;
      sync2_ff <= i_pin;
      prev_ff <= i_pin;
    end else begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // falling when the select bit is set, rising otherwise
  assign hit = i_edge_fall ? (prev_ff & ~sync2_ff) : (~prev_ff & sync2_ff);

  // pending latch; not reset, an edge wins over a software write
  always_ff @(posedge i_mclk) begin
    if (hit) begin
      pend_ff <= 1'b1;
    end else if (i_wr_pend) begin
      pend_ff <= i_wr_val;
    end
  end

  assign o_pend = pend_ff;

  a_edge_sets_pend: assert property (@(posedge i_mclk) disable iff (i_srst)
    hit |=> o_pend) else $error("edge did not set pending");
endmodule

// file: verilog/pdmiw_top.sv
// power-down control and multi-input wakeup for port b
`timescale 1ns/1ps
module pdmiw_top (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ext_reset_pin,
  input wire logic i_sleep_exec,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_clear,
  input wire logic [7:0] i_port_b,
  input wire pdmiw_pkg::pdmiw_cfg_s i_cfg,
  output logic [7:0] o_cfg_rdata,
  output logic [7:0] o_port_b_dir,
  output logic [7:0] o_wakeup_enable_mask,
  output logic [7:0] o_wakeup_edge_select,
  output logic o_sleeping,
  output logic o_core_run,
  output logic o_irq,
  output logic o_pc_load,
  output logic [10:0] o_pc_value,
  output logic o_wdt_overflow,
  output pdmiw_pkg::pdmiw_stat_s o_stat
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  pdmiw_pkg::pdmiw_state_e state_ff; // run state
  pdmiw_pkg::pdmiw_state_e nxt_state; // next run state
  logic [7:0] dir_ff; // pin direction
  logic [7:0] en_ff; // wakeup enable mask, active low
  logic [7:0] edge_ff; // edge select
  logic [7:0] pend; // pending bits from edge cells
  logic [7:0] rdata_ff; // swap return value
  logic [pdmiw_pkg::WDT_W-1:0] wdt_ff; // watchdog count
  logic wdt_ovf; // watchdog overflow this cycle
  logic wake_pin; // enabled pending bit present
  logic to_ff; // timeout flag
  logic pd_ff; // powerdown flag
  logic pcl_ff; // pc load pulse
  logic wr_pend; // write to pending register
  logic wr_en; // write to enable register
  logic wr_edge; // write to edge register
  logic wr_dir; // write to direction register

  ////////////////////////////////////////////////////////////////////////
  // selector decode
  always_comb begin
    wr_dir = 1'b0;
    wr_edge = 1'b0;
    wr_pend = 1'b0;
    wr_en = 1'b0;
    if (i_cfg.sel == pdmiw_pkg::SEL_DIR) begin
      wr_dir = i_cfg.wr;
    end else if (i_cfg.sel == pdmiw_pkg::SEL_EDGE) begin
      wr_edge = i_cfg.wr;
    end else if (i_cfg.sel == pdmiw_pkg::SEL_PEND) begin
      wr_pend = i_cfg.wr;
    end else if (i_cfg.sel == pdmiw_pkg::SEL_EN) begin
      wr_en = i_cfg.wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      en_ff <= pdmiw_pkg::EN_RESET;
      edge_ff <= pdmiw_pkg::EDGE_RESET;
      dir_ff <= pdmiw_pkg::DIR_RESET;
    end else begin
      if (wr_en) begin
        en_ff <= i_cfg.data;
      end
      if (wr_edge) begin
        edge_ff <= i_cfg.data;
      end
      if (wr_dir) begin
        dir_ff <= i_cfg.data;
      end
    end
  end

  // swap: pending bits return while new ones are written
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_ff <= pdmiw_pkg::ZERO8;
    end else if (wr_pend) begin
      rdata_ff <= pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin edge cells
  genvar gi;
  generate
    for (gi = 0; gi < pdmiw_pkg::NPIN; gi++) begin : g_pin
      pdmiw_edge u_edge (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_pin(i_port_b[gi]),
        .i_edge_fall(edge_ff[gi]),
        .i_wr_pend(wr_pend),
        .i_wr_val(i_cfg.data[gi]),
        .o_pend(pend[gi])
      );
    end
  endgenerate

  // cleared enable bit lets that pin's pending bit through
  assign wake_pin = |(pend & ~en_ff);

  ////////////////////////////////////////////////////////////////////////
  // watchdog counter, keeps running in power-down
  assign wdt_ovf = i_wdt_enable && (wdt_ff == pdmiw_pkg::WDT_MAX);
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wdt_ff <= pdmiw_pkg::WDT_ZERO;
    end else if (!i_wdt_enable || i_wdt_clear) begin
      wdt_ff <= pdmiw_pkg::WDT_ZERO;
    end else if (state_ff == pdmiw_pkg::PDMIW_RUN && i_sleep_exec) begin
      wdt_ff <= pdmiw_pkg::WDT_ZERO;
    end else begin
      wdt_ff <= wdt_ff + pdmiw_pkg::WDT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // run state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pdmiw_pkg::PDMIW_RUN: begin
        if (i_sleep_exec) begin
          nxt_state = pdmiw_pkg::PDMIW_SLEEP;
        end
      end
      pdmiw_pkg::PDMIW_SLEEP: begin
        if (wake_pin || wdt_ovf) begin
          nxt_state = pdmiw_pkg::PDMIW_WAKE;
        end
      end
      pdmiw_pkg::PDMIW_WAKE: begin
        nxt_state = pdmiw_pkg::PDMIW_RUN;
      end
      default: begin
        nxt_state = pdmiw_pkg::PDMIW_RUN;
      end
    endcase
  end

  // external reset pin ends sleep like the device reset
  always_ff @(posedge i_mclk) begin
    if (i_srst || i_ext_reset_pin) begin
      state_ff <= pdmiw_pkg::PDMIW_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // status flags
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      to_ff <= 1'b1;
      pd_ff <= 1'b1;
    end else if (state_ff == pdmiw_pkg::PDMIW_RUN && i_sleep_exec && i_wdt_enable) begin
      to_ff <= 1'b1;
      pd_ff <= 1'b0;
    end
  end

  // pc reload pulse on leaving sleep by a wakeup or the reset pin
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pcl_ff <= 1'b0;
    end else begin
      pcl_ff <= (state_ff == pdmiw_pkg::PDMIW_SLEEP) && (nxt_state != state_ff || i_ext_reset_pin);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_pc_load = pcl_ff;
  assign o_pc_value = pdmiw_pkg::PC_RESET;
  assign o_sleeping = (state_ff == pdmiw_pkg::PDMIW_SLEEP);
  assign o_core_run = (state_ff == pdmiw_pkg::PDMIW_RUN);
  assign o_irq = o_core_run && wake_pin;
  assign o_wdt_overflow = wdt_ovf;
  assign o_cfg_rdata = rdata_ff;
  assign o_port_b_dir = dir_ff;
  assign o_wakeup_enable_mask = en_ff;
  assign o_wakeup_edge_select = edge_ff;
  assign o_stat = '{timeout_flag: to_ff, powerdown_flag: pd_ff};

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_sleep_enters: assert property (@(posedge i_mclk) disable iff (i_srst || i_ext_reset_pin)
    o_core_run && i_sleep_exec |=> o_sleeping) else $error("sleep not entered");
  a_sleep_flags: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_core_run && i_sleep_exec && i_wdt_enable |=> o_stat.timeout_flag && !o_stat.powerdown_flag)
    else $error("sleep flags wrong");
  a_pin_wakes: assert property (@(posedge i_mclk) disable iff (i_srst || i_ext_reset_pin)
    o_sleeping && wake_pin |=> !o_sleeping ##1 o_core_run) else $error("no pin wakeup");
  a_mask_blocks: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_sleeping && ((pend & ~en_ff) == pdmiw_pkg::ZERO8) && !wdt_ovf && !i_ext_reset_pin
    |=> o_sleeping)
    else $error("masked wake");
  a_reset_vals: assert property (@(posedge i_mclk)
    i_srst |=> en_ff == pdmiw_pkg::EN_RESET && edge_ff == pdmiw_pkg::EDGE_RESET)
    else $error("reset values wrong");
  a_pc_reload: assert property (@(posedge i_mclk) disable iff (i_srst || i_ext_reset_pin)
    o_sleeping && wake_pin |=> o_pc_load && o_pc_value == pdmiw_pkg::PC_RESET)
    else $error("pc not reloaded");
  a_swap_read: assert property (@(posedge i_mclk) disable iff (i_srst)
    wr_pend |=> o_cfg_rdata === $past(pend)) else $error("swap value wrong");
  a_irq_run: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_irq |-> o_core_run && wake_pin) else $error("irq while asleep");
endmodule

// file: tb/pdmiw_pin_model.sv
// port b pin driver standing in for the outside world
`timescale 1ns/1ps
module pdmiw_pin_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_level,
  input wire logic [1:0] i_lag,
  output logic [7:0] o_pins
);
  logic [1:0] wait_ff; // cycles waited so far
  // pins start high so that the first low level is a real fall
  initial begin
    o_pins = 8'hFF;
    wait_ff = 2'b00;
  end
  // follow the requested level, promptly or after a lag
  always @(negedge i_mclk) begin
    if (o_pins == i_level) begin
      wait_ff <= 2'b00;
    end else if (wait_ff >= i_lag) begin
      o_pins <= i_level;
    end else begin
      wait_ff <= wait_ff + 2'b01;
    end
  end
endmodule

// file: tb/tb.sv
// testbench for the power-down and multi-input wakeup block
`timescale 1ns/1ps
module tb;
  logic i_mclk, i_srst, i_ext_reset_pin, i_sleep_exec, i_wdt_enable, i_wdt_clear;
  logic [7:0] lvl, port_b, exp, o_cfg_rdata, o_port_b_dir;
  logic [7:0] o_wakeup_enable_mask, o_wakeup_edge_select;
  logic o_sleeping, o_core_run, o_irq, o_pc_load, o_wdt_overflow;
  logic pcl_seen, ovf_seen;
  logic [10:0] o_pc_value;
  logic [1:0] lag;
  pdmiw_pkg::pdmiw_cfg_s i_cfg;
  pdmiw_pkg::pdmiw_stat_s o_stat;
  int mismatches, tests_run, k;
  // rows: edge select, level before, level after
  logic [7:0] rows [4][3] = '{'{8'hFF, 8'hFF, 8'h00}, '{8'h00, 8'h00, 8'hFF},
    '{8'hA5, 8'h0F, 8'hF0}, '{8'h3C, 8'h55, 8'h55}};
  pdmiw_top i_pdmiw_top (.i_mclk(i_mclk), .i_srst(i_srst), .i_ext_reset_pin(i_ext_reset_pin),
    .i_sleep_exec(i_sleep_exec), .i_wdt_enable(i_wdt_enable), .i_wdt_clear(i_wdt_clear),
    .i_port_b(port_b), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata), .o_port_b_dir(o_port_b_dir),
    .o_wakeup_enable_mask(o_wakeup_enable_mask), .o_wakeup_edge_select(o_wakeup_edge_select),
    .o_sleeping(o_sleeping), .o_core_run(o_core_run), .o_irq(o_irq), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_wdt_overflow(o_wdt_overflow), .o_stat(o_stat));
  pdmiw_pin_model i_pdmiw_pin_model (.i_mclk(i_mclk), .i_level(lvl), .i_lag(lag),
    .o_pins(port_b));
  // clock source
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // one configuration write, wr held for one rising edge
  task automatic cfg(input logic [7:0] sel, input logic [7:0] data);
    @(negedge i_mclk);
    i_cfg = '{wr: 1'b1, sel: sel, data: data};
    @(negedge i_mclk);
    i_cfg.wr = 1'b0;
  endtask
  // one-cycle power-down instruction
  task automatic sleep_now();
    i_sleep_exec = 1'b1;
    @(negedge i_mclk);
    i_sleep_exec = 1'b0;
  endtask
  // bounded wait for the core to run again
  task automatic wait_run(input int n);
    k = 0;
    pcl_seen = 1'b0;
    ovf_seen = 1'b0;
    while (o_core_run !== 1'b1 && k < n) begin
      @(negedge i_mclk);
      k++;
      pcl_seen = pcl_seen | o_pc_load;
      ovf_seen = ovf_seen | o_wdt_overflow;
    end
    if (o_core_run !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // counts, verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    i_srst = 1'b1;
    i_ext_reset_pin = 1'b0;
    i_sleep_exec = 1'b0;
    i_wdt_enable = 1'b0;
    i_wdt_clear = 1'b0;
    i_cfg = '0;
    lvl = 8'hFF;
    lag = 2'b00;
    repeat (16) @(negedge i_mclk);
    i_srst = 1'b0;
    @(negedge i_mclk);
    chk({o_wakeup_enable_mask, o_wakeup_edge_select}, 16'hFFFF);
    chk({12'h000, o_stat, o_sleeping, o_core_run}, 16'h000D);
    // edge table, pending read back by swap
    foreach (rows[r]) begin
      lag = r[1:0];
      lvl = rows[r][1];
      repeat (10) @(negedge i_mclk);
      cfg(pdmiw_pkg::SEL_EDGE, rows[r][0]);
      cfg(pdmiw_pkg::SEL_PEND, 8'h00);
      lvl = rows[r][2];
      repeat (10) @(negedge i_mclk);
      exp = (rows[r][0] & rows[r][1] & ~rows[r][2]) | (~rows[r][0] & ~rows[r][1] & rows[r][2]);
      cfg(pdmiw_pkg::SEL_PEND, 8'h00);
      chk({o_wakeup_edge_select, o_cfg_rdata}, {rows[r][0], exp});
      chk({15'h0000, o_irq}, 16'h0000);
    end
    lag = 2'b00;
    cfg(pdmiw_pkg::SEL_DIR, 8'h07);
    cfg(8'h05, 8'h00);
    chk({o_wakeup_enable_mask, o_port_b_dir}, 16'hFF07);
    // pin 0 falling edge interrupts a running core
    cfg(pdmiw_pkg::SEL_EDGE, 8'h01);
    lvl = 8'hFF;
    repeat (10) @(negedge i_mclk);
    cfg(pdmiw_pkg::SEL_PEND, 8'h00);
    cfg(pdmiw_pkg::SEL_EN, 8'hFE);
    lvl = 8'hFE;
    repeat (10) @(negedge i_mclk);
    chk({14'h0000, o_irq, o_core_run}, 16'h0003);
    cfg(pdmiw_pkg::SEL_PEND, 8'h00);
    chk({7'h00, o_irq, o_cfg_rdata}, 16'h0001);
    // pin wake from power-down
    lvl = 8'hFF;
    repeat (10) @(negedge i_mclk);
    i_wdt_enable = 1'b1;
    sleep_now();
    chk({12'h000, o_stat, o_sleeping, o_core_run}, 16'h000A);
    lvl = 8'hFE;
    wait_run(20);
    chk({4'h0, pcl_seen, o_pc_value}, 16'h0FFF);
    // disabled pin keeps sleeping, reset pin wakes
    i_wdt_enable = 1'b0;
    cfg(pdmiw_pkg::SEL_EDGE, 8'h00);
    lvl = 8'hFC;
    repeat (10) @(negedge i_mclk);
    cfg(pdmiw_pkg::SEL_PEND, 8'h00);
    sleep_now();
    lvl = 8'hFE;
    repeat (12) @(negedge i_mclk);
    chk({15'h0000, o_sleeping}, 16'h0001);
    i_ext_reset_pin = 1'b1;
    wait_run(20);
    i_ext_reset_pin = 1'b0;
    chk({15'h0000, pcl_seen}, 16'h0001);
    // watchdog overflow wakes after a full count
    i_wdt_enable = 1'b1;
    i_wdt_clear = 1'b1;
    @(negedge i_mclk);
    i_wdt_clear = 1'b0;
    sleep_now();
    wait_run(70000);
    chk({14'h0000, ovf_seen, k > 65000 && k < 66000}, 16'h0003);
    // mid-run device reset reloads the configuration and flags
    i_srst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_srst = 1'b0;
    @(negedge i_mclk);
    chk({o_wakeup_enable_mask, o_wakeup_edge_select}, 16'hFFFF);
    chk({12'h000, o_stat, o_sleeping, o_core_run}, 16'h000D);
    tally_and_finish();
  end
endmodule
